// file: design/scbc_sensor_reference_clock_output.sv
// Prescaled M/N fractional divider that makes the sensor reference clock.
`timescale 1ns/100ps
module scbc_sensor_reference_clock_output (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_hs_tick,
    input  wire logic [2:0] i_prescale,
    input  wire logic [4:0] i_m,
    input  wire logic [7:0] i_n,
    output logic            o_clk
);
    logic [3:0] pre_cnt, next_pre_cnt, pre_lim;
    logic [8:0] acc, next_acc, sum;
    logic       next_clk;

    always_comb begin
        pre_lim = (i_prescale > 3'h4) ? 4'hF : 4'((5'h01 << i_prescale) - 5'h01);
        next_pre_cnt = pre_cnt;
        next_acc = acc;
        next_clk = o_clk;
        sum = acc + {3'h0, i_m, 1'b0};
        if (i_m == 5'h00) begin
            next_acc = 9'h000;
            next_clk = 1'b0;
            next_pre_cnt = 4'h0;
        end else if (i_hs_tick) begin
            next_pre_cnt = (pre_cnt >= pre_lim) ? 4'h0 : pre_cnt + 4'h1;
            // Twice M per prescaled tick, toggled on carry, gives rate times M over N.
            if (pre_cnt >= pre_lim && i_n != 8'h00) begin
                if (sum >= {1'b0, i_n}) begin
                    next_acc = sum - {1'b0, i_n};
                    next_clk = ~o_clk;
                end else begin
                    next_acc = sum;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pre_cnt <= 4'h0;
            acc     <= 9'h000;
            o_clk   <= 1'b0;
        end else begin
            pre_cnt <= next_pre_cnt;
            acc     <= next_acc;
            o_clk   <= next_clk;
        end
    end

    chk_sensor_reference_clock_output_muted: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_m == 5'h00 |=> !o_clk) else $error("Clock output not static with M zero.");
    // Muting with M zero is a legal edge off the tick, and a shrunk prescale ends its count late.
    chk_prescale_span: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $changed(o_clk) && $past(i_m) != 5'h00
        |-> $past(i_hs_tick) && $past(pre_cnt) >= $past(pre_lim))
        else $error("Toggle off prescale.");
    cov_clk_toggle: cover property (@(posedge i_sys_clk) disable iff (i_rst) $rose(o_clk));
endmodule // scbc_sensor_reference_clock_output

// file: design/scbc_top.sv
// APB register bank for legacy video mode, reference clocks and control channel watchdog.
//
// Summary of operation
// - After receive lock the control channel loads the RAW10 legacy mode bit.
// - After receive lock the control channel loads the RAW12 HF legacy mode bit.
// - Override enable blocks channel loading; software sets it to keep its bits.
// - Input divider codes 0 to 3 divide the reference by 1, 2, 4, 8.
// - Oscillator select picks the low or the double frequency range.
// - Divider source is the forward rate prescaled by 1 to 16; reset code 2.
// - Reference clock output equals prescaled clock times M over N.
// - M of zero stops the output clock at a static level.
// - Watchdog timeout is seven bits in 2 ms units, reset 0x7F, never zero; a written zero is taken as 128 units.
// - A transaction not done before timeout is ended.
// - Watchdog off bit set stops the watchdog; reset value zero runs it.
`timescale 1ns/100ps
`include "scbc_defs.svh"
module scbc_top #(
    parameter int WD_UNIT_CYC = `SCBC_WD_UNIT_CYC
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_rx_lock,
    input  wire logic        i_cc_mode_load,
    input  wire logic        i_cc_raw10,
    input  wire logic        i_cc_raw12,
    input  wire logic        i_hs_tick,
    input  wire logic        i_cc_txn_active,
    output logic             o_legacy_raw10_mode,
    output logic             o_legacy_raw12_hf_mode,
    output logic [1:0]       o_ref_input_div_log2,
    output logic             o_oscillator_range_select,
    output logic             o_sensor_reference_clock_output,
    output logic             o_cc_txn_abort
);
    // ****************************************************************
    // Register state.
    // ****************************************************************
    logic       raw10, next_raw10;
    logic       raw12, next_raw12;
    logic       ovr_en, next_ovr_en;
    logic [2:0] ref_div, next_ref_div;
    logic       osc_sel, next_osc_sel;
    logic [2:0] prescale, next_prescale;
    logic [4:0] div_m, next_div_m;
    logic [7:0] div_n, next_div_n;
    logic [6:0] wd_timer, next_wd_timer;
    logic       wd_off, next_wd_off;
    logic [1:0] next_ref_log2;

    // ****************************************************************
    // APB slave.
    // ****************************************************************
    logic [5:0]  idx;
    logic        mapped;
    logic        wr_en;
    logic        wr_leg;
    logic [7:0]  wd8;
    logic [7:0]  rd8;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;

    assign idx = i_paddr[7:2];
    assign wd8 = i_pwdata[7:0];

    always_comb begin
        mapped = (i_paddr[1:0] == 2'h0) &&
                 (idx >= `SCBC_IDX_LEGACY) && (idx <= `SCBC_IDX_WDOG);
        // Writes land only at the access edge that carries pready.
        wr_en = i_psel && i_penable && o_pready && i_pwrite && mapped;
        wr_leg = wr_en && (idx == `SCBC_IDX_LEGACY);
        case (idx)
            `SCBC_IDX_LEGACY: rd8 = {5'h00, raw10, raw12, ovr_en};
            `SCBC_IDX_PLLREF: rd8 = {1'b0, ref_div, osc_sel, `SCBC_RST_PLL_RSV};
            `SCBC_IDX_CLKLO:  rd8 = {prescale, div_m};
            `SCBC_IDX_CLKHI:  rd8 = div_n;
            `SCBC_IDX_WDOG:   rd8 = {wd_timer, wd_off};
            default:          rd8 = 8'h00;
        endcase
        next_pready = i_psel && !i_penable;
        next_pslverr = i_psel && !i_penable && !mapped;
        next_prdata = o_prdata;
        if (i_psel && !i_penable) begin
            next_prdata = (mapped && !i_pwrite) ? {24'h000000, rd8} : 32'h00000000;
        end
    end

    // ****************************************************************
    // Register next values.
    // ****************************************************************
    always_comb begin
        next_raw10 = raw10;
        next_raw12 = raw12;
        next_ovr_en = ovr_en;
        next_ref_div = ref_div;
        next_osc_sel = osc_sel;
        next_prescale = prescale;
        next_div_m = div_m;
        next_div_n = div_n;
        next_wd_timer = wd_timer;
        next_wd_off = wd_off;
        // A software write wins over a same-cycle channel load.
        if (wr_leg) begin
            next_raw10 = wd8[`SCBC_LEG_RAW10];
            next_raw12 = wd8[`SCBC_LEG_RAW12];
            next_ovr_en = wd8[`SCBC_LEG_OVR];
        end else if (i_cc_mode_load && i_rx_lock && !ovr_en) begin
            next_raw10 = i_cc_raw10;
            next_raw12 = i_cc_raw12;
        end
        if (wr_en && idx == `SCBC_IDX_PLLREF) begin
            next_ref_div = wd8[`SCBC_PLL_DIV_HI:`SCBC_PLL_DIV_LO];
            next_osc_sel = wd8[`SCBC_PLL_OSC];
        end
        if (wr_en && idx == `SCBC_IDX_CLKLO) begin
            next_prescale = wd8[`SCBC_CLO_PRE_HI:`SCBC_CLO_PRE_LO];
            next_div_m = wd8[`SCBC_CLO_M_HI:0];
        end
        if (wr_en && idx == `SCBC_IDX_CLKHI) begin
            next_div_n = wd8;
        end
        if (wr_en && idx == `SCBC_IDX_WDOG) begin
            next_wd_timer = wd8[`SCBC_WD_TMR_HI:`SCBC_WD_TMR_LO];
            next_wd_off = wd8[`SCBC_WD_OFF];
        end
        // Reserved divider codes fall back to divide by one.
        next_ref_log2 = ref_div[2] ? 2'h0 : ref_div[1:0];
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            raw10                     <= 1'b0;
            raw12                     <= 1'b0;
            ovr_en                    <= 1'b0;
            ref_div                   <= `SCBC_RST_REFDIV;
            osc_sel                   <= 1'b0;
            prescale                  <= `SCBC_RST_PRE;
            div_m                     <= `SCBC_RST_M;
            div_n                     <= `SCBC_RST_N;
            wd_timer                  <= `SCBC_RST_WDTMR;
            wd_off                    <= 1'b0;
            o_ref_input_div_log2      <= 2'h0;
            o_oscillator_range_select <= 1'b0;
            o_prdata                  <= 32'h00000000;
            o_pready                  <= 1'b0;
            o_pslverr                 <= 1'b0;
        end else begin
            raw10                     <= next_raw10;
            raw12                     <= next_raw12;
            ovr_en                    <= next_ovr_en;
            ref_div                   <= next_ref_div;
            osc_sel                   <= next_osc_sel;
            prescale                  <= next_prescale;
            div_m                     <= next_div_m;
            div_n                     <= next_div_n;
            wd_timer                  <= next_wd_timer;
            wd_off                    <= next_wd_off;
            o_ref_input_div_log2      <= next_ref_log2;
            o_oscillator_range_select <= osc_sel;
            o_prdata                  <= next_prdata;
            o_pready                  <= next_pready;
            o_pslverr                 <= next_pslverr;
        end
    end

    assign o_legacy_raw10_mode = raw10;
    assign o_legacy_raw12_hf_mode = raw12;

    // ****************************************************************
    // Clock output and watchdog.
    // ****************************************************************
    scbc_sensor_reference_clock_output u_sensor_reference_clock_output (
        .i_sys_clk  (i_sys_clk),
        .i_rst      (i_rst),
        .i_hs_tick  (i_hs_tick),
        .i_prescale (prescale),
        .i_m        (div_m),
        .i_n        (div_n),
        .o_clk      (o_sensor_reference_clock_output)
    );

    scbc_wdog #(
        .UNIT_CYC (WD_UNIT_CYC)
    ) u_wdog (
        .i_sys_clk    (i_sys_clk),
        .i_rst        (i_rst),
        .i_enable     (!wd_off),
        .i_timeout    (wd_timer),
        .i_txn_active (i_cc_txn_active),
        .o_abort      (o_cc_txn_abort)
    );

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    chk_raw10_load: assert property (
        i_cc_mode_load && i_rx_lock && !ovr_en && !wr_leg |=> raw10 == $past(i_cc_raw10))
        else $error("RAW10 bit not loaded by channel.");
    chk_raw12_load: assert property (
        i_cc_mode_load && i_rx_lock && !ovr_en && !wr_leg |=> raw12 == $past(i_cc_raw12))
        else $error("RAW12 bit not loaded by channel.");
    chk_override_hold: assert property (
        ovr_en && !wr_leg |=> $stable(raw10) && $stable(raw12))
        else $error("Mode bits changed under override.");
    chk_no_lock_hold: assert property (
        !i_rx_lock && !wr_leg |=> $stable(raw10) && $stable(raw12))
        else $error("Mode bits changed without lock.");
    chk_ref_divider: assert property (
        ##1 o_ref_input_div_log2 == ($past(ref_div[2]) ? 2'h0 : $past(ref_div[1:0])))
        else $error("Reference divider output wrong.");
    chk_osc_follow: assert property (
        $changed(osc_sel) |=> o_oscillator_range_select == $past(osc_sel))
        else $error("Oscillator select not forwarded.");
    chk_reserved_read: assert property (
        i_psel && !i_penable && !i_pwrite && idx == `SCBC_IDX_PLLREF && i_paddr[1:0] == 2'h0
        |=> o_prdata[7] == 1'b0 && o_prdata[2:0] == `SCBC_RST_PLL_RSV)
        else $error("Reserved field did not read default.");
    chk_apb_ready: assert property (
        i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("APB answer not one cycle after setup.");
    chk_wdog_write: assert property (
        wr_en && idx == `SCBC_IDX_WDOG |=> wd_timer == $past(wd8[7:1]))
        else $error("Watchdog timeout not written.");

    cov_cc_load: cover property (i_cc_mode_load && i_rx_lock && !ovr_en ##1 raw10);
    cov_apb_write: cover property (wr_en);
    cov_unmapped: cover property (o_pslverr);
endmodule // scbc_top

// file: design/scbc_wdog.sv
// Control channel transaction watchdog counting in 2 ms units.
`timescale 1ns/100ps
module scbc_wdog #(
    parameter int UNIT_CYC = 200000
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_enable,
    input  wire logic [6:0] i_timeout,
    input  wire logic       i_txn_active,
    output logic            o_abort
);
    localparam int CW = $clog2(UNIT_CYC + 1);
    scbc_pkg::scbc_wd_state_t state, next_state;
    logic [CW-1:0] cyc, next_cyc;
    logic [6:0]    units, next_units;
    logic          next_abort;

    always_comb begin
        next_state = state;
        next_cyc = cyc;
        next_units = units;
        next_abort = 1'b0;
        case (state)
            scbc_pkg::SCBC_WD_IDLE: begin
                next_cyc = '0;
                next_units = 7'h00;
                if (i_txn_active && i_enable) begin
                    next_state = scbc_pkg::SCBC_WD_RUN;
                end
            end
            scbc_pkg::SCBC_WD_RUN: begin
                if (!i_txn_active || !i_enable) begin
                    next_state = scbc_pkg::SCBC_WD_IDLE;
                end else if (cyc == CW'(UNIT_CYC - 1)) begin
                    next_cyc = '0;
                    next_units = units + 7'h01;
                    // A zero timeout wraps to 128 units rather than firing at once.
                    if (units == i_timeout - 7'h01) begin
                        next_abort = 1'b1;
                        next_state = scbc_pkg::SCBC_WD_EXPIRED;
                    end
                end else begin
                    next_cyc = cyc + CW'(1);
                end
            end
            scbc_pkg::SCBC_WD_EXPIRED: begin
                if (!i_txn_active) begin
                    next_state = scbc_pkg::SCBC_WD_IDLE;
                end
            end
            default: next_state = scbc_pkg::SCBC_WD_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state   <= scbc_pkg::SCBC_WD_IDLE;
            cyc     <= '0;
            units   <= 7'h00;
            o_abort <= 1'b0;
        end else begin
            state   <= next_state;
            cyc     <= next_cyc;
            units   <= next_units;
            o_abort <= next_abort;
        end
    end

    chk_wdog_disabled: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_enable |=> !o_abort) else $error("Abort while watchdog disabled.");
    chk_abort_single: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_abort |-> state == scbc_pkg::SCBC_WD_EXPIRED ##1 !o_abort)
        else $error("Abort not a single pulse.");
    cov_abort: cover property (@(posedge i_sys_clk) disable iff (i_rst) o_abort);
endmodule // scbc_wdog

// file: pkg/scbc_defs.svh
// Offsets, field positions, reset values and timing counts of the clock and channel config.
`ifndef SCBC_DEFS_SVH
`define SCBC_DEFS_SVH

// ****************************************************************
// Register indices; byte address is four times the index.
// ****************************************************************
`define SCBC_IDX_LEGACY   6'h04
`define SCBC_IDX_PLLREF   6'h05
`define SCBC_IDX_CLKLO    6'h06
`define SCBC_IDX_CLKHI    6'h07
`define SCBC_IDX_WDOG     6'h08

// ****************************************************************
// Field positions.
// ****************************************************************
`define SCBC_LEG_RAW10    2
`define SCBC_LEG_RAW12    1
`define SCBC_LEG_OVR      0
`define SCBC_PLL_DIV_HI   6
`define SCBC_PLL_DIV_LO   4
`define SCBC_PLL_OSC      3
`define SCBC_CLO_PRE_HI   7
`define SCBC_CLO_PRE_LO   5
`define SCBC_CLO_M_HI     4
`define SCBC_WD_TMR_HI    7
`define SCBC_WD_TMR_LO    1
`define SCBC_WD_OFF       0

// ****************************************************************
// Reset values.
// ****************************************************************
`define SCBC_RST_REFDIV   3'h0
`define SCBC_RST_PLL_RSV  3'h3
`define SCBC_RST_PRE      3'h2
`define SCBC_RST_M        5'h01
`define SCBC_RST_N        8'h28
`define SCBC_RST_WDTMR    7'h7F

// ****************************************************************
// Timing.
// ****************************************************************
`define SCBC_CLK_MHZ      100
`define SCBC_WD_UNIT_MS   2
`define SCBC_WD_UNIT_CYC  (`SCBC_WD_UNIT_MS * 1000 * `SCBC_CLK_MHZ)

`endif

// file: pkg/scbc_pkg.sv
// Types shared by the clock and channel config block.
package scbc_pkg;
    typedef enum logic [1:0] {
        SCBC_WD_IDLE    = 2'b00,
        SCBC_WD_RUN     = 2'b01,
        SCBC_WD_EXPIRED = 2'b11
    } scbc_wd_state_t;
endpackage

// file: verif/scbc_deser_model.sv
// Behavioural model of the companion deserializer on the control channel side.
`timescale 1ns/100ps
module scbc_deser_model (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_load_req,
    input  wire logic [1:0] i_load_bits,
    input  wire logic       i_txn_start,
    input  wire logic [7:0] i_txn_len,
    output logic            o_cc_mode_load,
    output logic            o_cc_raw10,
    output logic            o_cc_raw12,
    output logic            o_cc_txn_active,
    output logic            o_hs_tick
);
    logic [7:0] left;
    logic [1:0] last;

    // Off the strobe the mode lines carry the inverse of the last bits, so a design
    // that samples them without the load pulse picks up wrong values.
    assign o_cc_raw10 = o_cc_mode_load ? last[1] : ~last[1];
    assign o_cc_raw12 = o_cc_mode_load ? last[0] : ~last[0];

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cc_mode_load  <= 1'b0;
            o_cc_txn_active <= 1'b0;
            o_hs_tick       <= 1'b0;
            last            <= 2'h0;
            left            <= 8'h00;
        end else begin
            o_cc_mode_load <= i_load_req;
            o_hs_tick      <= ~o_hs_tick;
            if (i_load_req) begin
                last <= i_load_bits;
            end
            if (i_txn_start) begin
                o_cc_txn_active <= 1'b1;
                left            <= i_txn_len;
            end else if (left != 8'h00) begin
                left <= left - 8'h01;
                if (left == 8'h01) begin
                    o_cc_txn_active <= 1'b0;
                end
            end
        end
    end
endmodule // scbc_deser_model

// file: verif/serializer_clock_and_bcc_config_tb_top.sv
// Self-checking bench of the clock and control channel config bank.
`timescale 1ns/100ps
`include "scbc_defs.svh"
module serializer_clock_and_bcc_config_tb_top;
    localparam int         UNIT = 4;
    localparam logic [2:0] PV [4] = '{3'h0, 3'h1, 3'h4, 3'h0};
    localparam logic [4:0] MV [4] = '{5'h01, 5'h02, 5'h01, 5'h00};
    localparam logic [7:0] NV [4] = '{8'h04, 8'h08, 8'h02, 8'h04};
    localparam int         EV [4] = '{200, 100, 25, 0};
    localparam logic [7:0] WV [4] = '{8'h06, 8'h06, 8'h07, 8'h02};
    localparam logic [7:0] WL [4] = '{8'h3C, 8'h08, 8'h3C, 8'h1E};
    localparam int         WLO [4] = '{3 * UNIT, 0, 0, UNIT};

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, lock = 1'b0, load, raw10, raw12, active, tick;
    logic        abort, r10, r12, osc, cko;
    logic [1:0]  divl;
    logic        load_req = 1'b0;
    logic [1:0]  load_bits = 2'h0;
    logic        txn_start = 1'b0;
    logic [7:0]  txn_len = 8'h00;
    int          n_errors = 0;
    int          compares = 0;

    always #5 sys_clk = ~sys_clk;

    scbc_top #(.WD_UNIT_CYC(UNIT)) scbc_top_inst (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_rx_lock(lock),
        .i_cc_mode_load(load), .i_cc_raw10(raw10), .i_cc_raw12(raw12),
        .i_hs_tick(tick), .i_cc_txn_active(active), .o_legacy_raw10_mode(r10),
        .o_legacy_raw12_hf_mode(r12), .o_ref_input_div_log2(divl),
        .o_oscillator_range_select(osc), .o_sensor_reference_clock_output(cko),
        .o_cc_txn_abort(abort));

    scbc_deser_model scbc_deser_model_inst (
        .i_sys_clk(sys_clk), .i_rst(rst), .i_load_req(load_req),
        .i_load_bits(load_bits), .i_txn_start(txn_start), .i_txn_len(txn_len),
        .o_cc_mode_load(load), .o_cc_raw10(raw10), .o_cc_raw12(raw12),
        .o_cc_txn_active(active), .o_hs_tick(tick));

    // ****************************************************************
    // Bus and comparison tasks.
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // The request is left standing so that a further call starts its setup at once.
    task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        chk(pready, 32'h1);
        r = prdata;
        e = pslverr;
    endtask

    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb({i, 2'h0}, 1'b1, d, r, e);
        chk(e, 32'h0);
    endtask

    task automatic rd(input logic [5:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic        e;
        apb({i, 2'h0}, 1'b0, 8'h00, r, e);
        chk(r, {24'h0, x});
        chk(e, 32'h0);
    endtask

    task automatic cc_load(input logic [1:0] b);
        load_req  <= 1'b1;
        load_bits <= b;
        @(posedge sys_clk);
        load_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic final_report();
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        final_report();
    end

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        logic [31:0] r;
        logic        e;
        logic        prev;
        int          cnt;
        int          first;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(`SCBC_IDX_LEGACY, 8'h00);
        rd(`SCBC_IDX_PLLREF, 8'h03);
        rd(`SCBC_IDX_CLKLO, 8'h41);
        rd(`SCBC_IDX_CLKHI, 8'h28);
        rd(`SCBC_IDX_WDOG, 8'hFE);
        apb(8'h0C, 1'b1, 8'hFF, r, e);
        chk(e, 32'h1);
        apb(8'h11, 1'b1, 8'hFF, r, e);
        chk(e, 32'h1);
        apb(8'h24, 1'b0, 8'h00, r, e);
        chk({r[30:0], e}, 32'h1);
        rd(`SCBC_IDX_LEGACY, 8'h00);
        wr(`SCBC_IDX_LEGACY, 8'hFF);
        rd(`SCBC_IDX_LEGACY, 8'h07);
        wr(`SCBC_IDX_PLLREF, 8'hFF);
        rd(`SCBC_IDX_PLLREF, 8'h7B);
        for (int c = 0; c < 8; c++) begin
            wr(`SCBC_IDX_PLLREF, {1'b0, c[2:0], c[0], 3'h0});
            idle();
            @(posedge sys_clk);
            chk(divl, c < 4 ? c[1:0] : 2'h0);
            chk(osc, c[0]);
        end
        wr(`SCBC_IDX_LEGACY, 8'h00);
        idle();
        lock <= 1'b1;
        cc_load(2'h2);
        chk({r10, r12}, 32'h2);
        cc_load(2'h1);
        chk({r10, r12}, 32'h1);
        lock <= 1'b0;
        cc_load(2'h2);
        chk({r10, r12}, 32'h1);
        lock <= 1'b1;
        wr(`SCBC_IDX_LEGACY, 8'h05);
        idle();
        cc_load(2'h1);
        chk({r10, r12}, 32'h2);
        rd(`SCBC_IDX_LEGACY, 8'h05);
        for (int k = 0; k < 4; k++) begin
            wr(`SCBC_IDX_CLKHI, NV[k]);
            wr(`SCBC_IDX_CLKLO, {PV[k], MV[k]});
            idle();
            repeat (40) @(posedge sys_clk);
            cnt = 0;
            prev = cko;
            repeat (1600) begin
                @(posedge sys_clk);
                cnt += (cko === 1'b1 && prev === 1'b0);
                prev = cko;
            end
            chk(cnt + (EV[k] > 0) >= EV[k] && cnt <= EV[k] + (EV[k] > 0), 1);
        end
        for (int k = 0; k < 4; k++) begin
            wr(`SCBC_IDX_WDOG, WV[k]);
            idle();
            txn_len   <= WL[k];
            txn_start <= 1'b1;
            @(posedge sys_clk);
            txn_start <= 1'b0;
            cnt = 0;
            first = 0;
            for (int t = 1; t < 80; t++) begin
                @(posedge sys_clk);
                if (abort === 1'b1) begin
                    cnt++;
                    first = (first == 0) ? t : first;
                end
            end
            chk(cnt, WLO[k] > 0);
            chk(first >= WLO[k] && first <= WLO[k] + 4, 1);
        end
        final_report();
    end
endmodule // serializer_clock_and_bcc_config_tb_top
